//--- rtl/scs_config_store.sv
// Configuration store, command decode and raw sample output sequencer
// Behaviour
// - Raw output only with unity bridge/temperature gains
// - Raw bytes: bridge high, low, temperature
// - Temperature byte drops top six bits
// - Second-order term applies to one target
// - Bits 2:0 select oscillator trim
// - Bits 8:7 select converter input range
// - Bits 10:9 select output format
// - Bits 12:11 select update period
// - Bits 14:13 select supply regulation
// - Command 30 nibble selects configuration field
// - Command 40 data 00 resumes normal
`timescale 1ns/100ps
`default_nettype none
module scs_config_store #(
    parameter int PERIOD_CYC_0 = scs_pkg::PERIOD_US_0 * scs_pkg::CYC_PER_US,
    parameter int PERIOD_CYC_1 = scs_pkg::PERIOD_US_1 * scs_pkg::CYC_PER_US,
    parameter int PERIOD_CYC_2 = scs_pkg::PERIOD_US_2 * scs_pkg::CYC_PER_US,
    parameter int PERIOD_CYC_3 = scs_pkg::PERIOD_US_3 * scs_pkg::CYC_PER_US
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Decoded command from the serial link
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic [7:0] cmd_data_i,
    // Converter results
    input wire logic [scs_pkg::BR_W-1:0] bridge_raw_i,
    input wire logic [13:0] temp_raw_i,
    input wire logic [scs_pkg::BR_W-1:0] bridge_corr_i,
    input wire logic [7:0] temp_corr_i,
    // Byte stream to the serial output
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic last_byte_o,
    input wire logic byte_ready_i,
    // Configuration fields
    output logic [2:0] osc_trim_o,
    output logic [3:0] ref_trim_o,
    output logic [1:0] adc_range_o,
    output logic [1:0] out_format_o,
    output logic [1:0] sample_period_o,
    output logic [1:0] supply_reg_o,
    output logic invert_bridge_o,
    // Coefficients
    output logic [14:0] gain_bridge_o,
    output logic [13:0] offset_bridge_o,
    output logic [7:0] gain_temp_o,
    output logic [7:0] offset_temp_o,
    output logic [7:0] ptat_ref_o,
    output logic [7:0] tcg_o,
    output logic [7:0] tco_o,
    output logic [3:0] tempco_options_o,
    output logic [7:0] second_order_term_o,
    output logic [1:0] pamp_gain_o,
    // Second-order target, one-hot
    output logic second_order_on_bridge_o,
    output logic second_order_on_tcg_o,
    output logic second_order_on_tco_o,
    // Status
    output logic command_mode_o,
    output logic raw_mode_o,
    output logic raw_active_o
);
    import scs_pkg::*;

    typedef enum logic [1:0] {SCS_IDLE, SCS_BR_HI, SCS_BR_LO, SCS_TEMP} scs_seq_t;

    typedef struct packed {
        logic [2:0] osc;
        logic [3:0] rtrim;
        logic [1:0] range;
        logic [1:0] fmt;
        logic [1:0] period;
        logic [1:0] sreg;
        logic [14:0] gainb;
        logic [13:0] offb;
        logic [7:0] gaint;
        logic [7:0] offt;
        logic [7:0] ptat;
        logic [7:0] tcg;
        logic [7:0] tco;
        logic [3:0] tccfg;
        logic [7:0] second_order_term;
        logic [1:0] sotcfg;
        logic [1:0] pamp;
        logic cmd_mode;
        logic raw_mode;
        logic [2:0] sot_hot;
        logic raw_act;
        logic bvalid;
        logic [7:0] bdata;
        logic blast;
        logic [13:0] br_lat;
        logic [7:0] tp_lat;
        logic send_temp;
        scs_seq_t seq;
    } scs_st_t;

    scs_st_t st_r;
    scs_st_t st_nxt;
    logic tick;
    logic [3:0] sub_sel;
    logic [3:0] sub_dat;

    scs_period_tick #(
        .P0(PERIOD_CYC_0),
        .P1(PERIOD_CYC_1),
        .P2(PERIOD_CYC_2),
        .P3(PERIOD_CYC_3)
    ) u_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(st_r.period),
        .tick_o(tick)
    );

    assign sub_sel = cmd_data_i[7:4];
    assign sub_dat = cmd_data_i[3:0];

    always_comb begin
        st_nxt = st_r;
        // Command decode; programming accepted only in command mode
        if (cmd_valid_i) begin
            if (cmd_byte_i == CMD_ENTER) begin
                st_nxt.cmd_mode = 1'b1;
            end else if (st_r.cmd_mode) begin
                unique case (cmd_byte_i)
                    CMD_CONFIG: begin
                        unique case (sub_sel)
                            SEL_OSC: st_nxt.osc = sub_dat[2:0];
                            SEL_REF: st_nxt.rtrim = sub_dat;
                            SEL_RANGE: st_nxt.range = sub_dat[1:0];
                            SEL_OUT: st_nxt.fmt = sub_dat[1:0];
                            SEL_RATE: st_nxt.period = sub_dat[1:0];
                            SEL_REG: st_nxt.sreg = sub_dat[1:0];
                            SEL_TCCFG: st_nxt.tccfg = sub_dat;
                            SEL_SOTCFG: begin
                                // Prohibited code 11 is refused, keeping one target
                                if (sub_dat[3:2] != 2'h3) begin
                                    st_nxt.sotcfg = sub_dat[3:2];
                                end
                                st_nxt.pamp = sub_dat[1:0];
                            end
                            default: st_nxt.osc = st_r.osc;
                        endcase
                    end
                    CMD_MODE: begin
                        if (cmd_data_i == DATA_NORMAL) begin
                            st_nxt.cmd_mode = 1'b0;
                            st_nxt.raw_mode = 1'b0;
                        end else if (cmd_data_i[4]) begin
                            st_nxt.raw_mode = 1'b1;
                        end
                    end
                    CMD_SOT: st_nxt.second_order_term = cmd_data_i;
                    CMD_PTAT_REF: st_nxt.ptat = cmd_data_i;
                    CMD_GAINB_HI: st_nxt.gainb[14:8] = cmd_data_i[6:0];
                    CMD_GAINB_LO: st_nxt.gainb[7:0] = cmd_data_i;
                    CMD_OFFB_HI: st_nxt.offb[13:8] = cmd_data_i[5:0];
                    CMD_OFFB_LO: st_nxt.offb[7:0] = cmd_data_i;
                    CMD_GAINT: st_nxt.gaint = cmd_data_i;
                    CMD_OFFT: st_nxt.offt = cmd_data_i;
                    CMD_TCO: st_nxt.tco = cmd_data_i;
                    CMD_TCG: st_nxt.tcg = cmd_data_i;
                    default: st_nxt.cmd_mode = st_r.cmd_mode;
                endcase
            end
        end
        // One-hot decode keeps the second-order term on exactly one target
        unique case (st_nxt.sotcfg)
            SOT_TCG: st_nxt.sot_hot = 3'h2;
            SOT_TCO: st_nxt.sot_hot = 3'h4;
            default: st_nxt.sot_hot = 3'h1;
        endcase
        // Taken from the next values so raw output never outlives unity gains
        st_nxt.raw_act = st_nxt.raw_mode && (st_nxt.gainb == GAINB_UNITY)
            && (st_nxt.gaint == GAINT_UNITY);
        // Output byte sequencer
        if (st_r.bvalid && byte_ready_i) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.blast = 1'b0;
        end
        unique case (st_r.seq)
            SCS_IDLE: begin
                // Analog formats send no bytes unless raw output is active; active raw output (raw mode with unity gains) always sends three
                if (tick && (st_r.fmt == OUT_DIG3 || st_r.fmt == OUT_DIG2 || st_r.raw_act)) begin
                    if (st_r.raw_act) begin
                        st_nxt.br_lat = bridge_raw_i;
                        st_nxt.tp_lat = temp_raw_i[7:0];
                        st_nxt.send_temp = 1'b1;
                    end else begin
                        st_nxt.br_lat = bridge_corr_i;
                        st_nxt.tp_lat = temp_corr_i;
                        st_nxt.send_temp = (st_r.fmt == OUT_DIG3);
                    end
                    st_nxt.seq = SCS_BR_HI;
                end
            end
            SCS_BR_HI: begin
                if (!st_r.bvalid) begin
                    st_nxt.bvalid = 1'b1;
                    st_nxt.bdata = {2'h0, st_r.br_lat[13:8]};
                    st_nxt.seq = SCS_BR_LO;
                end
            end
            SCS_BR_LO: begin
                if (!st_nxt.bvalid) begin
                    st_nxt.bvalid = 1'b1;
                    st_nxt.bdata = st_r.br_lat[7:0];
                    st_nxt.blast = !st_r.send_temp;
                    st_nxt.seq = st_r.send_temp ? SCS_TEMP : SCS_IDLE;
                end
            end
            SCS_TEMP: begin
                if (!st_nxt.bvalid) begin
                    st_nxt.bvalid = 1'b1;
                    st_nxt.bdata = st_r.tp_lat;
                    st_nxt.blast = 1'b1;
                    st_nxt.seq = SCS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.osc <= OSC_RST;
            st_r.rtrim <= REF_RST;
            st_r.range <= RANGE_RST;
            st_r.fmt <= OUT_RST;
            st_r.period <= RATE_RST;
            st_r.sreg <= REG_RST;
            st_r.pamp <= PAMP_RST;
            st_r.sot_hot <= 3'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign osc_trim_o = st_r.osc;
    assign ref_trim_o = st_r.rtrim;
    assign adc_range_o = st_r.range;
    assign out_format_o = st_r.fmt;
    assign sample_period_o = st_r.period;
    assign supply_reg_o = st_r.sreg;
    assign invert_bridge_o = st_r.tccfg[3];
    assign gain_bridge_o = st_r.gainb;
    assign offset_bridge_o = st_r.offb;
    assign gain_temp_o = st_r.gaint;
    assign offset_temp_o = st_r.offt;
    assign ptat_ref_o = st_r.ptat;
    assign tcg_o = st_r.tcg;
    assign tco_o = st_r.tco;
    assign tempco_options_o = st_r.tccfg;
    assign second_order_term_o = st_r.second_order_term;
    assign pamp_gain_o = st_r.pamp;
    assign second_order_on_bridge_o = st_r.sot_hot[0];
    assign second_order_on_tcg_o = st_r.sot_hot[1];
    assign second_order_on_tco_o = st_r.sot_hot[2];
    assign command_mode_o = st_r.cmd_mode;
    assign raw_mode_o = st_r.raw_mode;
    assign raw_active_o = st_r.raw_act;
    assign byte_valid_o = st_r.bvalid;
    assign byte_o = st_r.bdata;
    assign last_byte_o = st_r.blast;

    a_sot_onehot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $onehot(st_r.sot_hot)) else $error("second-order target not one-hot");
    a_raw_unity: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        raw_active_o |-> (gain_bridge_o == 15'h0800 && gain_temp_o == 8'h80))
        else $error("raw output without unity gains");
    a_enter_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cmd_valid_i && cmd_byte_i == 8'h50) |=> command_mode_o)
        else $error("enter command ignored");
    a_normal_exit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cmd_valid_i && command_mode_o && cmd_byte_i == 8'h40 && cmd_data_i == 8'h00)
        |=> (!command_mode_o && !raw_mode_o)) else $error("normal resume failed");
    a_raw_needs_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(raw_mode_o) |-> $past(command_mode_o)) else $error("raw mode outside cmd");
    a_out_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cmd_valid_i && command_mode_o && cmd_byte_i == 8'h30 && cmd_data_i[7:4] == 4'h3)
        |=> (out_format_o == $past(cmd_data_i[1:0]))) else $error("output select lost");
    a_osc_trim: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cmd_valid_i && command_mode_o && cmd_byte_i == 8'h30 && cmd_data_i[7:4] == 4'h0)
        |=> (osc_trim_o == $past(cmd_data_i[2:0]))) else $error("oscillator trim lost");
    a_bridge_top: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st_r.seq == SCS_BR_HI && !st_r.bvalid) |=> (byte_valid_o && byte_o[7:6] == 2'h0))
        else $error("bridge high top bits not zero");
    a_no_write_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cmd_valid_i && !command_mode_o && cmd_byte_i == 8'h30) |=> $stable(out_format_o))
        else $error("config written outside command mode");
    sequence s_byte_waiting;
        byte_valid_o && !byte_ready_i;
    endsequence
    a_byte_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_byte_waiting |=> (byte_valid_o && $stable(byte_o) && $stable(last_byte_o)))
        else $error("output byte changed before taken");
endmodule
`default_nettype wire

//--- pkg/scs_pkg.sv
// Constants for the sensor calibration configuration store
package scs_pkg;
    // Command bytes
    localparam logic [7:0] CMD_CONFIG = 8'h30;
    localparam logic [7:0] CMD_MODE = 8'h40;
    localparam logic [7:0] CMD_ENTER = 8'h50;
    localparam logic [7:0] CMD_SOT = 8'h60;
    localparam logic [7:0] CMD_PTAT_REF = 8'h70;
    localparam logic [7:0] CMD_GAINB_HI = 8'h80;
    localparam logic [7:0] CMD_GAINB_LO = 8'h90;
    localparam logic [7:0] CMD_OFFB_HI = 8'ha0;
    localparam logic [7:0] CMD_OFFB_LO = 8'hb0;
    localparam logic [7:0] CMD_GAINT = 8'hc0;
    localparam logic [7:0] CMD_OFFT = 8'hd0;
    localparam logic [7:0] CMD_TCO = 8'he0;
    localparam logic [7:0] CMD_TCG = 8'hf0;
    // Mode command data
    localparam logic [7:0] DATA_NORMAL = 8'h00;
    localparam logic [7:0] DATA_RAW = 8'h10;
    // Command 30 sub-selectors (third nibble)
    localparam logic [3:0] SEL_OSC = 4'h0;
    localparam logic [3:0] SEL_REF = 4'h1;
    localparam logic [3:0] SEL_RANGE = 4'h2;
    localparam logic [3:0] SEL_OUT = 4'h3;
    localparam logic [3:0] SEL_RATE = 4'h4;
    localparam logic [3:0] SEL_REG = 4'h5;
    localparam logic [3:0] SEL_TCCFG = 4'h6;
    localparam logic [3:0] SEL_SOTCFG = 4'h7;
    // Unity gain values
    localparam logic [14:0] GAINB_UNITY = 15'h0800;
    localparam logic [7:0] GAINT_UNITY = 8'h80;
    // Output format codes
    localparam logic [1:0] OUT_DIG3 = 2'h0;
    localparam logic [1:0] OUT_ANA1V = 2'h1;
    localparam logic [1:0] OUT_RATIO = 2'h2;
    localparam logic [1:0] OUT_DIG2 = 2'h3;
    // Second-order target codes
    localparam logic [1:0] SOT_BRIDGE = 2'h0;
    localparam logic [1:0] SOT_TCG = 2'h1;
    localparam logic [1:0] SOT_TCO = 2'h2;
    // Reset values of the configuration fields
    localparam logic [2:0] OSC_RST = 3'h0;
    localparam logic [3:0] REF_RST = 4'h0;
    localparam logic [1:0] RANGE_RST = 2'h0;
    localparam logic [1:0] OUT_RST = 2'h0;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [1:0] REG_RST = 2'h0;
    localparam logic [1:0] PAMP_RST = 2'h1;
    // Sample periods
    localparam int CLK_HZ = 20000000;
    localparam int PERIOD_US_0 = 1000;
    localparam int PERIOD_US_1 = 5000;
    localparam int PERIOD_US_2 = 25000;
    localparam int PERIOD_US_3 = 125000;
    localparam int CYC_PER_US = CLK_HZ / 1000000;
    // Bit widths
    localparam int BR_W = 14;
    localparam int TEMP_W = 11;
endpackage

//--- rtl/scs_period_tick.sv
// Sample period divider, one-cycle tick per update period
`timescale 1ns/100ps
`default_nettype none
module scs_period_tick #(
    parameter int P0 = 20000,
    parameter int P1 = 100000,
    parameter int P2 = 500000,
    parameter int P3 = 2500000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    typedef struct packed {
        logic [21:0] cnt;
        logic tick;
    } spt_st_t;
    spt_st_t st_r;
    spt_st_t st_nxt;
    logic [21:0] limit;

    always_comb begin
        unique case (sel_i)
            2'h0: limit = 22'(P0 - 1);
            2'h1: limit = 22'(P1 - 1);
            2'h2: limit = 22'(P2 - 1);
            2'h3: limit = 22'(P3 - 1);
        endcase
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        // A shortened period restarts at once rather than waiting out the old count
        if (st_r.cnt >= limit) begin
            st_nxt.cnt = 22'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 22'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule
`default_nettype wire

//--- verif/scs_host_model.sv
// Calibration host model driving commands and taking output bytes
`timescale 1ns/100ps
`default_nettype none
module scs_host_model (
    // Clock
    input wire logic clk_i,
    // Command port
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o,
    output logic [7:0] cmd_data_o,
    // Byte stream
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic last_byte_i,
    output logic byte_ready_o
);
    int timeouts = 0;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_byte_o = 8'h00;
        cmd_data_o = 8'h00;
        byte_ready_o = 1'b0;
    end
    task automatic send(input logic [7:0] c, input logic [7:0] d);
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_byte_o = c;
        cmd_data_o = d;
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        // Idle bus shows junk so a stale command never looks valid
        cmd_byte_o = ~c;
        cmd_data_o = ~d;
    endtask
    task automatic get_byte(input int stall, output logic [7:0] b, output logic l);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (byte_valid_i !== 1'b1 && n < 400);
        if (n >= 400) timeouts++;
        repeat (stall) @(negedge clk_i);
        // Byte stands until the taking edge, so it is read while settled
        b = byte_i;
        l = last_byte_i;
        byte_ready_o = 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        byte_ready_o = 1'b0;
    endtask
    // Noise-free inputs, so the average must be exact
    task automatic sample_point(output logic [13:0] br, output logic [7:0] tp);
        logic [7:0] h, lo, t;
        logic l;
        int sb;
        int st;
        sb = 0;
        st = 0;
        for (int i = 0; i < 16; i++) begin
            get_byte(i % 3, h, l);
            get_byte(0, lo, l);
            get_byte(2, t, l);
            sb += {h[5:0], lo};
            st += t;
        end
        br = 14'(sb / 16);
        tp = 8'(st / 16);
    endtask
endmodule
`default_nettype wire

//--- verif/scs_config_store_tb.sv
// Self-checking bench for the configuration store
`timescale 1ns/100ps
`default_nettype none
module scs_config_store_tb;
    import scs_pkg::*;
    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] lsb;
        logic [3:0] mask;
    } scs_row_t;
    localparam scs_row_t ROWS [6] = '{
        '{SEL_OSC, 4'h0, 4'h7},
        '{SEL_REF, 4'h3, 4'hf},
        '{SEL_RANGE, 4'h7, 4'h3},
        '{SEL_OUT, 4'h9, 4'h3},
        '{SEL_RATE, 4'hb, 4'h3},
        '{SEL_REG, 4'hd, 4'h3}
    };
    localparam int PER [4] = '{20, 40, 60, 80};
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid_i, byte_valid_o, last_byte_o, byte_ready_i, invert_bridge_o, l, seen;
    logic [7:0] cmd_byte_i, cmd_data_i, byte_o, temp_corr_i, gain_temp_o, offset_temp_o, b, tp;
    logic [7:0] ptat_ref_o, tcg_o, tco_o, second_order_term_o;
    logic [13:0] bridge_raw_i, temp_raw_i, bridge_corr_i, offset_bridge_o, br;
    logic [14:0] gain_bridge_o, exp_cfg, cfg;
    logic [2:0] osc_trim_o;
    logic [3:0] ref_trim_o, tempco_options_o;
    logic [1:0] adc_range_o, out_format_o, sample_period_o, supply_reg_o, pamp_gain_o;
    logic second_order_on_bridge_o, second_order_on_tcg_o, second_order_on_tco_o;
    logic command_mode_o, raw_mode_o, raw_active_o;
    logic [8:0] stat;
    realtime t0;
    int errors = 0;
    int comparisons = 0;
    assign cfg = {supply_reg_o, sample_period_o, out_format_o, adc_range_o, ref_trim_o,
        osc_trim_o};
    assign stat = {pamp_gain_o, second_order_on_bridge_o, second_order_on_tcg_o,
        second_order_on_tco_o, command_mode_o, raw_mode_o, raw_active_o, byte_valid_o};
    always #25 clk_i = ~clk_i;
    // Short periods keep the run brief
    scs_config_store #(
        .PERIOD_CYC_0(20), .PERIOD_CYC_1(40), .PERIOD_CYC_2(60), .PERIOD_CYC_3(80)
    ) dut (.*);
    scs_host_model host (
        .clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_byte_o(cmd_byte_i),
        .cmd_data_o(cmd_data_i), .byte_valid_i(byte_valid_o), .byte_i(byte_o),
        .last_byte_i(last_byte_o), .byte_ready_o(byte_ready_i)
    );
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] exp, input logic el, input int stall);
        host.get_byte(stall, b, l);
        cmp({7'h00, l, b}, {7'h00, el, exp});
    endtask
    // First frame may have been latched before the last change
    task automatic finish_frame;
        do host.get_byte(0, b, l); while (l !== 1'b1);
    endtask
    task automatic give_verdict;
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        errors++;
        give_verdict();
    end
    initial begin
        bridge_raw_i = 14'h2a5c;
        temp_raw_i = 14'h1b7e;
        bridge_corr_i = 14'h1234;
        temp_corr_i = 8'h9c;
        exp_cfg = 15'h0000;
        repeat (20) @(negedge clk_i);
        sys_rst_i = 1'b0;
        cmp({7'h00, stat}, 16'h00c0);
        host.send(CMD_CONFIG, 8'h37);
        cmp({1'b0, cfg}, 16'h0000);
        host.send(CMD_ENTER, 8'h00);
        cmp({15'h0, command_mode_o}, 16'h0001);
        for (int r = 0; r < 6; r++) begin
            for (int v = 15; v >= 0; v--) begin
                host.send(CMD_CONFIG, {ROWS[r].sel, 4'(v)});
                exp_cfg = exp_cfg & ~(15'(ROWS[r].mask) << ROWS[r].lsb);
                exp_cfg = exp_cfg | ((15'(v) & 15'(ROWS[r].mask)) << ROWS[r].lsb);
                cmp({1'b0, cfg}, {1'b0, exp_cfg});
            end
        end
        host.send(CMD_CONFIG, 8'h87);
        cmp({1'b0, cfg}, 16'h0000);
        for (int t = 0; t < 4; t++) begin
            host.send(CMD_CONFIG, {SEL_SOTCFG, 2'(t), 2'(t)});
            cmp({11'h0, second_order_on_bridge_o, second_order_on_tcg_o,
                second_order_on_tco_o, pamp_gain_o},
                {11'h0, t == 0, t == 1, t >= 2, 2'(t)});
        end
        host.send(CMD_PTAT_REF, 8'h5a);
        host.send(CMD_TCG, 8'hc3);
        host.send(CMD_TCO, 8'h3c);
        host.send(CMD_GAINB_HI, 8'h08);
        host.send(CMD_GAINB_LO, 8'h00);
        host.send(CMD_GAINT, GAINT_UNITY);
        cmp({ptat_ref_o, tcg_o}, 16'h5ac3);
        cmp({8'h00, tco_o}, 16'h003c);
        cmp({1'b0, gain_bridge_o}, 16'h0800);
        cmp({8'h00, gain_temp_o}, 16'h0080);
        host.send(CMD_CONFIG, {SEL_TCCFG, 4'h9});
        host.send(CMD_SOT, 8'ha5);
        host.send(CMD_OFFB_HI, 8'hea);
        host.send(CMD_OFFB_LO, 8'h5c);
        host.send(CMD_OFFT, 8'h77);
        cmp({11'h0, invert_bridge_o, tempco_options_o}, 16'h0019);
        cmp({2'h0, offset_bridge_o}, 16'h2a5c);
        cmp({offset_temp_o, second_order_term_o}, 16'h77a5);
        host.send(CMD_MODE, DATA_RAW);
        @(negedge clk_i);
        cmp({14'h0, raw_mode_o, raw_active_o}, 16'h0003);
        finish_frame();
        cmp_byte(8'h2a, 1'b0, 3);
        cmp_byte(8'h5c, 1'b0, 0);
        cmp_byte(8'h7e, 1'b1, 1);
        for (int p = 0; p < 2; p++) begin
            bridge_raw_i = p ? 14'h3fff : 14'h0155;
            temp_raw_i = p ? 14'h00e1 : 14'h3f07;
            finish_frame();
            host.sample_point(br, tp);
            cmp({2'h0, br}, p ? 16'h3fff : 16'h0155);
            cmp({8'h00, tp}, p ? 16'h00e1 : 16'h0007);
        end
        host.send(CMD_PTAT_REF, 8'h11);
        host.send(CMD_TCG, 8'h22);
        host.send(CMD_TCO, 8'h33);
        cmp({ptat_ref_o, tcg_o}, 16'h1122);
        cmp({8'h00, tco_o}, 16'h0033);
        host.send(CMD_GAINT, 8'h81);
        @(negedge clk_i);
        cmp({15'h0, raw_active_o}, 16'h0000);
        finish_frame();
        cmp_byte(8'h12, 1'b0, 0);
        cmp_byte(8'h34, 1'b0, 2);
        cmp_byte(8'h9c, 1'b1, 0);
        for (int c = 3; c >= 0; c--) begin
            host.send(CMD_CONFIG, {SEL_RATE, 4'(c)});
            finish_frame();
            host.get_byte(0, b, l);
            t0 = $realtime;
            finish_frame();
            host.get_byte(0, b, l);
            cmp(16'(int'(($realtime - t0) / 50.0)), 16'(PER[c]));
            finish_frame();
        end
        host.send(CMD_CONFIG, {SEL_OUT, 4'h3});
        finish_frame();
        cmp_byte(8'h12, 1'b0, 0);
        cmp_byte(8'h34, 1'b1, 0);
        host.send(CMD_CONFIG, {SEL_OUT, 4'h1});
        repeat (3) @(negedge clk_i);
        if (byte_valid_o === 1'b1) finish_frame();
        seen = 1'b0;
        repeat (200) begin
            @(negedge clk_i);
            if (byte_valid_o !== 1'b0) seen = 1'b1;
        end
        cmp({15'h0, seen}, 16'h0000);
        host.send(CMD_MODE, 8'h05);
        cmp({15'h0, command_mode_o}, 16'h0001);
        host.send(CMD_MODE, DATA_NORMAL);
        cmp({14'h0, command_mode_o, raw_mode_o}, 16'h0000);
        host.send(CMD_CONFIG, {SEL_OUT, 4'h0});
        cmp({14'h0, out_format_o}, 16'h0001);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        cmp({7'h00, stat}, 16'h00c0);
        cmp({1'b0, cfg}, 16'h0000);
        cmp(16'(host.timeouts), 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
